// >>> srcdec_device.sv
// Source address decoder: small I/O, large I/O and DRAM range decoders
`timescale 1ns/1ps

// Overview of operation
// - I/O match overrides DRAM match
// - I/O regions typed MMIO, PCI config config-space
// - I/O range: fixed node or list entry
// - Twenty DRAM limits, contiguous ranges
// - Entry zero uses one valid bit
// - Limits compared at 256 MB granularity
// - DRAM type, list indexed low or hashed
// - Hemisphere inverts node bit 1
// - Non-coherent regions keep identical targets
// - Unused top entries repeat limit, nonexistent
// - Prime top limits downward, then real
// - Replicated entries keep distinct high index
// - Eight-way list plus base forms node
// - High-order index sits below region size
// - Hemisphere only with low interleave, bit 1; code also applies it with hashed index
// - DRAM low only, I/O high only
// - Priority small, large, then DRAM
// - Same address to all, one hit each
// - Matched region yields attribute and node
// - Match above previous limit, within own
// - Slots hold node 4:1, base bit 0
// - Valid bit and limits reset zero
module srcdec_device (
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          SRST,
  // Link to the caching agent
  srcdec_if.device           LINK,
  // Observation
  output srcdec_pkg::srcdec_src_t RSP_SOURCE,
  output logic               ENTRY0_VALID
);
  import srcdec_pkg::*;

  // ***************************************************************
  // Decoder storage
  // ***************************************************************
  srcdec_dram_t   dram [N_DRAM];
  srcdec_io_t     small_io_decoder  [N_IO];
  srcdec_io_t     large_io_decoder  [N_IO];
  logic           valid0;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < N_DRAM; i++) begin
        dram[i] <= DRAM_RST;
      end
    end else if (LINK.dram_we) begin
      dram[LINK.dram_idx] <= LINK.dram_data;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < N_IO; i++) begin
        small_io_decoder[i] <= IO_RST;
        large_io_decoder[i] <= IO_RST;
      end
    end else if (LINK.io_we) begin
      if (LINK.io_large) begin
        large_io_decoder[LINK.io_idx] <= LINK.io_data;
      end else begin
        small_io_decoder[LINK.io_idx] <= LINK.io_data;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      valid0 <= VALID0_RST;
    end else if (LINK.valid0_we) begin
      valid0 <= LINK.valid0_data;
    end
  end

  assign ENTRY0_VALID = valid0;

  // ***************************************************************
  // Decode functions
  // ***************************************************************
  // Naturally aligned power-of-two window, size at least 2^15
  function automatic logic io_hit(srcdec_io_t e, logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] base;
    mask   = {ADDR_W{1'b1}} << e.size_log2;
    base   = {e.base, {IO_BASE_LSB{1'b0}}};
    io_hit = e.enable && ((a & mask) == (base & mask));
  endfunction : io_hit

  function automatic logic [NODE_W-1:0] io_node(srcdec_io_t e,
                                                logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] sh;
    logic [2:0]        idx;
    logic [SLOT_W-1:0] slot;
    sh   = a >> (e.size_log2 - IO_IDX_SPAN);
    idx  = sh[2:0];
    slot = e.tgtlist[{idx, 2'b00} +: SLOT_W];
    io_node = e.fixed ? e.node : {slot, e.idbase};
  endfunction : io_node

  // ***************************************************************
  // Parallel match
  // ***************************************************************
  logic [N_IO-1:0]    ios_hit;
  logic [N_IO-1:0]    iol_hit;
  logic [N_DRAM-1:0]  dram_le;
  logic [N_DRAM-1:0]  dram_hit;
  logic [LIM_W-1:0]   addr_hi;

  // only bits above 256 MB compared
  assign addr_hi = LINK.req_addr[ADDR_W-1:LIM_LSB];

  for (genvar g = 0; g < N_IO; g++) begin : g_io
    assign ios_hit[g] = io_hit(small_io_decoder[g], LINK.req_addr);
    assign iol_hit[g] = io_hit(large_io_decoder[g], LINK.req_addr);
  end

  for (genvar g = 0; g < N_DRAM; g++) begin : g_dram
    assign dram_le[g] = (addr_hi <= dram[g].limit);
    if (g == 0) begin : g_first
      assign dram_hit[g] = dram_le[g] & valid0;
    end else begin : g_rest
      assign dram_hit[g] = dram_le[g] & ~dram_le[g-1];
    end
  end

  // ***************************************************************
  // Selection within each decoder
  // ***************************************************************
  // Only one hit per decoder is legal; lowest index wins otherwise
  srcdec_io_t     ios_sel;
  srcdec_io_t     iol_sel;
  srcdec_dram_t   dram_sel;
  logic           ios_any;
  logic           iol_any;
  logic           dram_any;

  always_comb begin
    ios_sel = IO_RST;
    iol_sel = IO_RST;
    ios_any = 1'b0;
    iol_any = 1'b0;
    for (int i = 0; i < N_IO; i++) begin
      if (ios_hit[i] && !ios_any) begin
        ios_any = 1'b1;
        ios_sel = small_io_decoder[i];
      end
      if (iol_hit[i] && !iol_any) begin
        iol_any = 1'b1;
        iol_sel = large_io_decoder[i];
      end
    end
  end

  always_comb begin
    dram_sel = DRAM_RST;
    dram_any = 1'b0;
    for (int i = 0; i < N_DRAM; i++) begin
      if (dram_hit[i] && !dram_any) begin
        dram_any = 1'b1;
        dram_sel = dram[i];
      end
    end
  end

  // ***************************************************************
  // DRAM node generation
  // ***************************************************************
  logic [2:0]         low_idx;
  logic [2:0]         dram_idx;
  logic               hemi_bit;
  logic [NODE_W-1:0]  dram_node;

  assign low_idx  = LINK.req_addr[LOW_IDX_LSB +: 3];
  assign hemi_bit = LINK.req_addr[HEMI_BIT_A] ^ LINK.req_addr[HEMI_BIT_B]
                  ^ LINK.req_addr[HEMI_BIT_C] ^ LINK.req_addr[HEMI_BIT_D];

  always_comb begin
    dram_idx = dram_sel.tgtsel ? low_idx
                               : low_idx ^ LINK.req_addr[MID_IDX_LSB +: 3];
    // slot gives 4:1, base gives 0
    dram_node = {dram_sel.tgtlist[{dram_idx, 2'b00} +: SLOT_W],
                 dram_sel.idbase};
    if (dram_sel.hemi) begin
      dram_node[NODE_HEMI] = dram_node[NODE_HEMI] ^ hemi_bit;
    end
  end

  // ***************************************************************
  // Priority and answer
  // ***************************************************************
  logic               next_hit;
  srcdec_attr_t       next_attr;
  logic [NODE_W-1:0]  next_node;
  srcdec_src_t        next_src;

  always_comb begin
    next_hit  = 1'b1;
    next_attr = ATTR_NONEXISTENT_MEMORY_TYPE;
    next_node = LOCAL_NODE;
    next_src  = SRC_NONE;
    if (ios_any) begin
      next_attr = ios_sel.attr;
      next_node = io_node(ios_sel, LINK.req_addr);
      next_src  = SRC_SMALL;
    end else if (iol_any) begin
      next_attr = iol_sel.attr;
      next_node = io_node(iol_sel, LINK.req_addr);
      next_src  = SRC_LARGE;
    end else if (dram_any) begin
      next_attr = dram_sel.attr;
      next_src  = SRC_DRAM;
      // Holes go to the local configuration agent
      if (dram_sel.attr != ATTR_NONEXISTENT_MEMORY_TYPE) begin
        next_node = dram_node;
      end
    end else begin
      next_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      LINK.rsp_valid <= 1'b0;
    end else begin
      LINK.rsp_valid <= LINK.req_valid;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      LINK.rsp_hit  <= 1'b0;
      LINK.rsp_attr <= ATTR_NONEXISTENT_MEMORY_TYPE;
      LINK.rsp_node <= LOCAL_NODE;
      RSP_SOURCE    <= SRC_NONE;
    end else if (LINK.req_valid) begin
      LINK.rsp_hit  <= next_hit;
      LINK.rsp_attr <= next_attr;
      LINK.rsp_node <= next_node;
      RSP_SOURCE    <= next_src;
    end
  end

endmodule : srcdec_device

// >>> srcdec_pkg.sv
// Shared constants and types for the source address decoder and its agent
package srcdec_pkg;

  // ***************************************************************
  // Widths and sizes
  // ***************************************************************
  localparam int ADDR_W      = 44;
  localparam int N_DRAM      = 20;
  localparam int N_IO        = 4;
  localparam int DRAM_IDX_W  = 5;
  localparam int IO_IDX_W    = 2;
  localparam int NODE_W      = 5;
  localparam int TGT_W       = 32;
  localparam int SLOT_W      = 4;
  localparam int SIZE_W      = 6;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  // 256 MB limit granularity
  localparam int LIM_LSB     = 28;
  localparam int LIM_W       = ADDR_W - LIM_LSB;
  localparam int IO_BASE_LSB = 12;
  localparam int LOW_IDX_LSB = 6;
  localparam int MID_IDX_LSB = 16;
  localparam int HEMI_BIT_A  = 19;
  localparam int HEMI_BIT_B  = 13;
  localparam int HEMI_BIT_C  = 10;
  localparam int HEMI_BIT_D  = 6;
  localparam int NODE_HEMI   = 1;
  localparam logic [SIZE_W-1:0] IO_IDX_SPAN = 6'h03;

  // ***************************************************************
  // Memory attributes
  // ***************************************************************
  typedef enum logic [2:0] {
    ATTR_COHERENT          = 3'h0,
    ATTR_MMIO              = 3'h1,
    ATTR_LEGACY_IO         = 3'h2,
    ATTR_CONFIG_SPACE_TYPE = 3'h4,
    ATTR_NONEXISTENT_MEMORY_TYPE = 3'h7
  } srcdec_attr_t;

  // Which sub-decoder produced the answer
  typedef enum logic [1:0] {
    SRC_NONE  = 2'h0,
    SRC_SMALL = 2'h1,
    SRC_LARGE = 2'h2,
    SRC_DRAM  = 2'h3
  } srcdec_src_t;

  // ***************************************************************
  // Entry layouts
  // ***************************************************************
  typedef struct packed {
    logic [LIM_W-1:0] limit;
    logic [TGT_W-1:0] tgtlist;
    logic             idbase;
    logic             hemi;
    logic             tgtsel;
    srcdec_attr_t     attr;
  } srcdec_dram_t;

  typedef struct packed {
    logic                          enable;
    logic [ADDR_W-1:IO_BASE_LSB]   base;
    logic [SIZE_W-1:0]             size_log2;
    srcdec_attr_t                  attr;
    logic                          fixed;
    logic [NODE_W-1:0]             node;
    logic [TGT_W-1:0]              tgtlist;
    logic                          idbase;
  } srcdec_io_t;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam srcdec_dram_t DRAM_RST = '{limit: 16'h0000,
                                        tgtlist: 32'h0000_0000,
                                        idbase: 1'b0, hemi: 1'b0,
                                        tgtsel: 1'b1,
                                        attr: ATTR_NONEXISTENT_MEMORY_TYPE};
  localparam srcdec_io_t IO_RST = '0;
  localparam logic             VALID0_RST = 1'b0;
  // Node of the local configuration agent; value is arbitrary
  localparam logic [NODE_W-1:0] LOCAL_NODE = 5'h00;
  localparam logic [LIM_W-1:0]  LIMIT_TOP  = 16'hFFFF;
  localparam logic [DRAM_IDX_W-1:0] DRAM_LAST = 5'h13;

endpackage : srcdec_pkg

// >>> srcdec_if.sv
// Link between the caching agent and the source address decoder
`timescale 1ns/1ps
interface srcdec_if;
  import srcdec_pkg::*;

  // Request and answer
  logic                    req_valid;
  logic [ADDR_W-1:0]       req_addr;
  logic                    rsp_valid;
  logic                    rsp_hit;
  srcdec_attr_t            rsp_attr;
  logic [NODE_W-1:0]       rsp_node;
  // Configuration writes
  logic                    dram_we;
  logic [DRAM_IDX_W-1:0]   dram_idx;
  srcdec_dram_t            dram_data;
  logic                    io_we;
  logic                    io_large;
  logic [IO_IDX_W-1:0]     io_idx;
  srcdec_io_t              io_data;
  logic                    valid0_we;
  logic                    valid0_data;

  modport device (
    input  req_valid, req_addr, dram_we, dram_idx, dram_data,
    input  io_we, io_large, io_idx, io_data, valid0_we, valid0_data,
    output rsp_valid, rsp_hit, rsp_attr, rsp_node
  );

  modport agent (
    output req_valid, req_addr, dram_we, dram_idx, dram_data,
    output io_we, io_large, io_idx, io_data, valid0_we, valid0_data,
    input  rsp_valid, rsp_hit, rsp_attr, rsp_node
  );

endinterface : srcdec_if

// >>> srcdec_agent.sv
// Caching-agent end: primes and configures the decoder, issues requests
`timescale 1ns/1ps
module srcdec_agent (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       SRST,
  // Link to the decoder
  srcdec_if.agent                         LINK,
  // Requests
  input  wire logic                       REQ_VALID,
  input  wire logic [srcdec_pkg::ADDR_W-1:0] REQ_ADDR,
  output logic                            REQ_READY,
  // Answers
  output logic                            RSP_VALID,
  output logic                            RSP_HIT,
  output srcdec_pkg::srcdec_attr_t        RSP_ATTR,
  output logic [srcdec_pkg::NODE_W-1:0]   RSP_NODE,
  // DRAM entry writes
  input  wire logic                       CFG_DRAM_WE,
  input  wire logic [srcdec_pkg::DRAM_IDX_W-1:0] CFG_DRAM_IDX,
  input  wire srcdec_pkg::srcdec_dram_t   CFG_DRAM_DATA,
  // I/O entry writes
  input  wire logic                       CFG_IO_WE,
  input  wire logic                       CFG_IO_LARGE,
  input  wire logic [srcdec_pkg::IO_IDX_W-1:0] CFG_IO_IDX,
  input  wire srcdec_pkg::srcdec_io_t     CFG_IO_DATA,
  input  wire logic                       CFG_IO_IS_PCICFG,
  // Entry zero valid bit
  input  wire logic                       CFG_VALID0_WE,
  input  wire logic                       CFG_VALID0,
  output logic                            CFG_READY
);
  import srcdec_pkg::*;

  // ***************************************************************
  // Priming sequence
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_PRIME = 2'b01,
    ST_RUN   = 2'b10
  } srcdec_state_t;

  srcdec_state_t            state;
  logic [DRAM_IDX_W-1:0]    prime_idx;

  // top limit written from entry 19 down
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state     <= ST_PRIME;
      prime_idx <= DRAM_LAST;
    end else begin
      case (state)
        ST_PRIME: begin
          if (prime_idx == '0) begin
            state <= ST_RUN;
          end else begin
            prime_idx <= prime_idx - 5'h01;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_PRIME;
        end
      endcase
    end
  end

  assign REQ_READY = (state == ST_RUN);
  assign CFG_READY = (state == ST_RUN);

  // ***************************************************************
  // Configuration fixes imposed by the agent
  // ***************************************************************
  srcdec_dram_t   fixed_dram;
  srcdec_io_t     fixed_io;

  always_comb begin
    fixed_dram = CFG_DRAM_DATA;
    if (CFG_DRAM_DATA.attr != ATTR_COHERENT) begin
      fixed_dram.tgtlist = {8{CFG_DRAM_DATA.tgtlist[SLOT_W-1:0]}};
      fixed_dram.tgtsel  = 1'b1;
      fixed_dram.hemi    = 1'b0;
    end
    fixed_io = CFG_IO_DATA;
    // I/O type is MMIO or config space
    fixed_io.attr = CFG_IO_IS_PCICFG ? ATTR_CONFIG_SPACE_TYPE : ATTR_MMIO;
  end

  // ***************************************************************
  // Link drive
  // ***************************************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      LINK.dram_we   <= 1'b0;
      LINK.dram_idx  <= '0;
      LINK.dram_data <= DRAM_RST;
    end else if (state == ST_PRIME) begin
      LINK.dram_we         <= 1'b1;
      LINK.dram_idx        <= prime_idx;
      LINK.dram_data       <= DRAM_RST;
      LINK.dram_data.limit <= LIMIT_TOP;
    end else begin
      LINK.dram_we   <= CFG_DRAM_WE;
      LINK.dram_idx  <= CFG_DRAM_IDX;
      LINK.dram_data <= fixed_dram;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      LINK.io_we       <= 1'b0;
      LINK.io_large    <= 1'b0;
      LINK.io_idx      <= '0;
      LINK.io_data     <= IO_RST;
      LINK.valid0_we   <= 1'b0;
      LINK.valid0_data <= VALID0_RST;
    end else begin
      LINK.io_we       <= CFG_IO_WE && (state == ST_RUN);
      LINK.io_large    <= CFG_IO_LARGE;
      LINK.io_idx      <= CFG_IO_IDX;
      LINK.io_data     <= fixed_io;
      LINK.valid0_we   <= CFG_VALID0_WE && (state == ST_RUN);
      LINK.valid0_data <= CFG_VALID0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      LINK.req_valid <= 1'b0;
      LINK.req_addr  <= '0;
    end else begin
      LINK.req_valid <= REQ_VALID && (state == ST_RUN);
      LINK.req_addr  <= REQ_ADDR;
    end
  end

  // Answers are held until the next one arrives
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RSP_VALID <= 1'b0;
      RSP_HIT   <= 1'b0;
      RSP_ATTR  <= ATTR_NONEXISTENT_MEMORY_TYPE;
      RSP_NODE  <= LOCAL_NODE;
    end else begin
      RSP_VALID <= LINK.rsp_valid;
      if (LINK.rsp_valid) begin
        RSP_HIT  <= LINK.rsp_hit;
        RSP_ATTR <= LINK.rsp_attr;
        RSP_NODE <= LINK.rsp_node;
      end
    end
  end

endmodule : srcdec_agent

// >>> srcdec_assertions.sv
// Checker for the decoder link: answer timing and decode relations
`timescale 1ns/1ps
module srcdec_assertions (
  // Clock and reset
  input wire logic                          CLK,
  input wire logic                          SRST,
  // Request and answer
  input wire logic                          req_valid,
  input wire logic [srcdec_pkg::ADDR_W-1:0] req_addr,
  input wire logic                          rsp_valid,
  input wire logic                          rsp_hit,
  input wire srcdec_pkg::srcdec_attr_t      rsp_attr,
  input wire logic [srcdec_pkg::NODE_W-1:0] rsp_node,
  // Configuration strobes
  input wire logic                          dram_we,
  input wire logic [srcdec_pkg::DRAM_IDX_W-1:0] dram_idx,
  input wire srcdec_pkg::srcdec_dram_t      dram_data,
  input wire logic                          io_we,
  input wire logic                          valid0_we,
  input wire logic                          valid0_data
);
  import srcdec_pkg::*;

  // ********
  // Shadow state
  // ********
  // Entry zero is judged only while no I/O entry can override it
  logic [LIM_W-1:0] lim0;
  logic             v0;
  logic             io_seen;
  logic             cfg;

  assign cfg = dram_we | io_we | valid0_we;

  always_ff @(posedge CLK) begin
    if (SRST) lim0 <= '0;
    else if (dram_we && dram_idx == '0) lim0 <= dram_data.limit;
  end

  always_ff @(posedge CLK) begin
    if (SRST) v0 <= 1'b0;
    else if (valid0_we) v0 <= valid0_data;
  end

  always_ff @(posedge CLK) begin
    if (SRST) io_seen <= 1'b0;
    else if (io_we) io_seen <= 1'b1;
  end

  // ********
  // Properties
  // ********
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_two_req; req_valid ##1 req_valid; endsequence
  sequence s_two_rsp; rsp_valid ##1 rsp_valid; endsequence
  sequence s_same_req;
    (req_valid && !cfg) ##1 (req_valid && $stable(req_addr));
  endsequence

  property p_lat; req_valid |=> rsp_valid; endproperty
  a_lat: assert property (p_lat) else $error("answer missing");
  property p_quiet; !req_valid |=> !rsp_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer unasked");
  property p_hold;
    !req_valid |=> $stable(rsp_hit) && $stable(rsp_attr) && $stable(rsp_node);
  endproperty
  a_hold: assert property (p_hold) else $error("answer moved");
  property p_b2b; s_two_req |-> s_two_rsp; endproperty
  a_b2b: assert property (p_b2b) else $error("answer dropped");
  property p_same;
    s_same_req |=> $stable(rsp_hit) && $stable(rsp_attr) && $stable(rsp_node);
  endproperty
  a_same: assert property (p_same) else $error("answer varies");
  property p_miss;
    rsp_valid && !rsp_hit |-> rsp_attr == ATTR_NONEXISTENT_MEMORY_TYPE
                              && rsp_node == LOCAL_NODE;
  endproperty
  a_miss: assert property (p_miss) else $error("miss not default");
  property p_hole;
    rsp_valid && rsp_attr == ATTR_NONEXISTENT_MEMORY_TYPE
      |-> rsp_node == LOCAL_NODE;
  endproperty
  a_hole: assert property (p_hole) else $error("hole node wrong");
  property p_e0_off;
    req_valid && !v0 && !io_seen && req_addr[ADDR_W-1:LIM_LSB] <= lim0
      |=> !rsp_hit;
  endproperty
  a_e0_off: assert property (p_e0_off) else $error("entry zero hit");
  property p_e0_on;
    req_valid && v0 && !io_seen && req_addr[ADDR_W-1:LIM_LSB] <= lim0
      |=> rsp_hit;
  endproperty
  a_e0_on: assert property (p_e0_on) else $error("entry zero miss");
endmodule : srcdec_assertions

// >>> srcdec_tb_top.sv
// Testbench: agent and decoder joined by the link, user side driven
`timescale 1ns/1ps
module srcdec_tb_top;
  import srcdec_pkg::*;

  localparam srcdec_attr_t nomem = ATTR_NONEXISTENT_MEMORY_TYPE;
  // no slot of e0 or e1 is replicated
  localparam srcdec_dram_t e0 = '{16'h0000, 32'h7654_3210, 1'b1, 1'b0,
                                  1'b1, ATTR_COHERENT};
  localparam srcdec_dram_t e1 = '{16'h0001, 32'h3A5C_96F1, 1'b0, 1'b1,
                                  1'b0, ATTR_COHERENT};
  // List, hash and hemisphere must be dropped by the agent
  localparam srcdec_dram_t e2 = '{16'h0002, 32'h1234_5679, 1'b1, 1'b1,
                                  1'b0, ATTR_MMIO};
  localparam logic [ADDR_W-1:0] a1 = 44'h000_1000_0040;

  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  req_valid = 1'b0;
  logic [ADDR_W-1:0]     req_addr = '0;
  logic                  req_ready;
  logic                  rsp_valid;
  logic                  rsp_hit;
  srcdec_attr_t          rsp_attr;
  logic [NODE_W-1:0]     rsp_node;
  logic                  dram_we = 1'b0;
  logic [DRAM_IDX_W-1:0] dram_idx = '0;
  srcdec_dram_t          dram_data = DRAM_RST;
  logic                  io_we = 1'b0;
  logic                  io_large = 1'b0;
  logic [IO_IDX_W-1:0]   io_idx = '0;
  srcdec_io_t            io_data = IO_RST;
  logic                  io_pcicfg = 1'b0;
  logic                  v0_we = 1'b0;
  logic                  v0 = 1'b0;
  logic                  cfg_ready;
  srcdec_src_t           source;
  logic                  entry0_valid;
  int                    miscompares = 0;
  int                    checks_done = 0;

  always #20 clk = ~clk;

  srcdec_if link ();
  srcdec_device i_srcdec_device (.CLK(clk), .SRST(srst), .LINK(link),
    .RSP_SOURCE(source), .ENTRY0_VALID(entry0_valid));
  srcdec_agent i_srcdec_agent (.CLK(clk), .SRST(srst), .LINK(link),
    .REQ_VALID(req_valid), .REQ_ADDR(req_addr), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_HIT(rsp_hit), .RSP_ATTR(rsp_attr),
    .RSP_NODE(rsp_node), .CFG_DRAM_WE(dram_we), .CFG_DRAM_IDX(dram_idx),
    .CFG_DRAM_DATA(dram_data), .CFG_IO_WE(io_we), .CFG_IO_LARGE(io_large),
    .CFG_IO_IDX(io_idx), .CFG_IO_DATA(io_data),
    .CFG_IO_IS_PCICFG(io_pcicfg), .CFG_VALID0_WE(v0_we), .CFG_VALID0(v0),
    .CFG_READY(cfg_ready));
  srcdec_assertions i_srcdec_assertions (.CLK(clk), .SRST(srst),
    .req_valid(link.req_valid), .req_addr(link.req_addr),
    .rsp_valid(link.rsp_valid), .rsp_hit(link.rsp_hit),
    .rsp_attr(link.rsp_attr), .rsp_node(link.rsp_node),
    .dram_we(link.dram_we), .dram_idx(link.dram_idx),
    .dram_data(link.dram_data), .io_we(link.io_we),
    .valid0_we(link.valid0_we), .valid0_data(link.valid0_data));

  // ********
  // Stimulus and checks
  // ********
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t ns: seen %0h, expected %0h", $time, seen, exp);
    end
  endtask : check

  // expected node of a DRAM entry
  function automatic logic [NODE_W-1:0] dnode(srcdec_dram_t e,
                                               logic [ADDR_W-1:0] a);
    logic [2:0]        ix;
    logic [NODE_W-1:0] n;
    ix = e.tgtsel ? a[8:6] : a[8:6] ^ a[18:16];
    n = {e.tgtlist[ix*4 +: 4], e.idbase};
    if (e.hemi) n[1] = n[1] ^ a[19] ^ a[13] ^ a[10] ^ a[6];
    return n;
  endfunction : dnode

  task automatic ask(input logic [ADDR_W-1:0] a, input logic h,
                     input srcdec_attr_t at, input logic [NODE_W-1:0] nd,
                     input srcdec_src_t sr);
    int n;
    req_valid = 1'b1;
    req_addr = a;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    check(n, 2);
    check({rsp_hit, rsp_attr, rsp_node, source}, {h, at, nd, sr});
  endtask : ask

  task automatic put_dram(input logic [DRAM_IDX_W-1:0] i, input srcdec_dram_t d);
    dram_we = 1'b1;
    dram_idx = i;
    dram_data = d;
    @(negedge clk);
    dram_we = 1'b0;
    repeat (2) @(negedge clk);
  endtask : put_dram

  task automatic put_io(input logic lg, input logic [IO_IDX_W-1:0] i,
                        input logic pc, input srcdec_io_t d);
    io_we = 1'b1;
    io_large = lg;
    io_idx = i;
    io_pcicfg = pc;
    io_data = d;
    @(negedge clk);
    io_we = 1'b0;
    repeat (2) @(negedge clk);
  endtask : put_io

  // ********
  // Scenarios
  // ********
  // primed decoder matches nothing
  task automatic t_empty;
    check(entry0_valid, 1'b0);
    ask(44'h0, 1'b0, nomem, LOCAL_NODE, SRC_NONE);
    ask(44'hFFF_FFFF_FFFF, 1'b0, nomem, LOCAL_NODE, SRC_NONE);
    $display("test empty done");
  endtask : t_empty

  task automatic t_dram;
    logic [ADDR_W-1:0] a;
    put_dram(5'h00, e0);
    put_dram(5'h01, e1);
    put_dram(5'h02, e2);
    ask(44'h0, 1'b0, nomem, LOCAL_NODE, SRC_NONE);
    v0_we = 1'b1;
    v0 = 1'b1;
    @(negedge clk);
    v0_we = 1'b0;
    repeat (2) @(negedge clk);
    ask(44'h0, 1'b1, ATTR_COHERENT, 5'h01, SRC_DRAM);
    check(entry0_valid, 1'b1);
    for (int k = 0; k < 8; k++) begin
      a = ADDR_W'(k) << 6;
      ask(a, 1'b1, ATTR_COHERENT, dnode(e0, a), SRC_DRAM);
      a = 44'h000_1000_0000 | ADDR_W'(k) << 6 | ADDR_W'(k) << 10
          | ADDR_W'(k) << 13 | ADDR_W'(k ^ 3) << 16;
      ask(a, 1'b1, ATTR_COHERENT, dnode(e1, a), SRC_DRAM);
    end
    a = 44'h000_0FFF_FFFF;
    ask(a, 1'b1, ATTR_COHERENT, dnode(e0, a), SRC_DRAM);
    ask(a1, 1'b1, ATTR_COHERENT, dnode(e1, a1), SRC_DRAM);
    ask(44'h000_2ABC_DEC0, 1'b1, ATTR_MMIO, 5'h13, SRC_DRAM);
    ask(44'h000_3000_0000, 1'b1, nomem, LOCAL_NODE, SRC_DRAM);
    ask(44'hFFF_FFFF_FFFF, 1'b1, nomem, LOCAL_NODE, SRC_DRAM);
    $display("test dram done");
  endtask : t_dram

  task automatic t_io;
    logic [ADDR_W-1:0] a;
    put_io(1'b0, 2'h0, 1'b0,
           '{1'b1, '0, 6'h10, ATTR_COHERENT, 1'b1, 5'h0A, '0, 1'b0});
    put_io(1'b1, 2'h1, 1'b1,
           '{1'b1, '0, 6'h1C, ATTR_MMIO, 1'b0, 5'h00, 32'hFEDC_BA98, 1'b1});
    ask(44'h000_0000_2000, 1'b1, ATTR_MMIO, 5'h0A, SRC_SMALL);
    for (int k = 0; k < 8; k++) begin
      a = ADDR_W'(k) << 25 | 44'h000_0001_0000;
      ask(a, 1'b1, ATTR_CONFIG_SPACE_TYPE, NODE_W'((8 + k) * 2 + 1),
          SRC_LARGE);
    end
    put_io(1'b0, 2'h0, 1'b0, IO_RST);
    ask(44'h000_0000_2000, 1'b1, ATTR_CONFIG_SPACE_TYPE, 5'h11,
        SRC_LARGE);
    ask(a1, 1'b1, ATTR_COHERENT, dnode(e1, a1), SRC_DRAM);
    $display("test io done");
  endtask : t_io

  task automatic t_b2b;
    req_valid = 1'b1;
    req_addr = a1;
    repeat (2) @(negedge clk);
    req_addr = 44'h000_2000_0000;
    @(negedge clk);
    req_valid = 1'b0;
    for (int k = 0; k < 3; k++) begin
      check({rsp_valid, rsp_node},
            {1'b1, k < 2 ? dnode(e1, a1) : 5'h13});
      @(negedge clk);
    end
    $display("test back-to-back done");
  endtask : t_b2b

  // ********
  // Run control
  // ********
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    int n;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    n = 0;
    while (cfg_ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(req_ready, 1'b1);
    t_empty;
    t_dram;
    t_io;
    t_b2b;
    print_verdict;
  end

  // Scenarios need about 160 cycles; some eighteen times that means a hang
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
endmodule : srcdec_tb_top
